// ---- dcc_analog_model.sv ----
// behavioural analog comparator: input muxes plus decision.
// assumes pin levels and the reference are given in 96ths of span.
`timescale 1ns/1ns
`default_nettype none
module dcc_analog_model (
	input wire logic on,
	input wire logic plus_select,
	input wire logic minus_select,
	input wire logic ref_power,
	input wire logic [6:0] ref_fraction,
	input wire logic [6:0] plus_pin,
	input wire logic [6:0] minus_pin,
	output logic raw
);
	logic [6:0] vplus;
	logic [6:0] vminus;
	// an unpowered ladder sits at the low rail
	assign vplus = plus_select ? plus_pin :
		(ref_power ? ref_fraction : 7'h00);
	assign vminus = minus_select ? plus_pin : minus_pin;
	// a disabled comparator gives no decision
	assign raw = on & (vplus > vminus);
endmodule
`default_nettype wire

// ---- dcc_pkg.sv ----
// constants for the dual comparator control block: register map, field
// positions, reset values and the reference ladder arithmetic.
// assumes a 32-bit AXI4-Lite register bus with byte addresses.
`default_nettype none
package dcc_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CMP_CTRL = 8'h00;
	localparam logic [7:0] ADDR_REF_CTRL = 8'h04;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
	localparam logic [7:0] ADDR_INT_MASK = 8'h0C;

	// comparator_control field positions
	localparam int IDLE_STOP_BIT = 15;
	localparam int EVT_B_BIT = 13;
	localparam int EVT_A_BIT = 12;
	localparam int ON_B_BIT = 11;
	localparam int ON_A_BIT = 10;
	localparam int PAD_B_BIT = 9;
	localparam int PAD_A_BIT = 8;
	localparam int RES_B_BIT = 7;
	localparam int RES_A_BIT = 6;
	localparam int INV_B_BIT = 5;
	localparam int INV_A_BIT = 4;
	localparam int MINUS_B_BIT = 3;
	localparam int PLUS_B_BIT = 2;
	localparam int MINUS_A_BIT = 1;
	localparam int PLUS_A_BIT = 0;
	// plain read/write bits; events and results are handled apart
	localparam logic [15:0] CMP_CTRL_WMASK = 16'h8F3F;
	localparam logic [15:0] CMP_CTRL_RESET = 16'h0000;

	// reference_level_control field positions
	localparam int REF_POWER_BIT = 7;
	localparam int REF_PIN_BIT = 6;
	localparam int REF_RANGE_BIT = 5;
	localparam int REF_SRC_BIT = 4;
	localparam int REF_LEVEL_LSB = 0;
	localparam int REF_LEVEL_W = 4;
	localparam logic [15:0] REF_CTRL_WMASK = 16'h00FF;
	localparam logic [15:0] REF_CTRL_RESET = 16'h0000;

	// interrupt status and mask layout
	localparam int INT_A_BIT = 0;
	localparam int INT_B_BIT = 1;
	localparam logic [1:0] INT_STATUS_RESET = 2'h0;
	localparam logic [1:0] INT_MASK_RESET = 2'h0;

	// reference level as a fraction of the source span, in 96ths:
	// fine range level/24 = 4*level/96, coarse 1/4 + level/32
	localparam int REF_DENOM = 96;
	localparam int REF_FRAC_W = 7;
	localparam logic [6:0] REF_FINE_STEP = 7'h04;
	localparam logic [6:0] REF_COARSE_STEP = 7'h03;
	localparam logic [6:0] REF_COARSE_BASE = 7'h18;
	localparam logic [6:0] REF_FRAC_RESET = 7'h18;

	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ---- dcc_top.sv ----
// dual comparator control: control/status registers, result capture,
// change events, interrupt, pad drive and reference ladder selection.
// assumes the analog front end reports each comparator's raw decision
// (selected plus input above selected minus input) as a digital level.
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// R1: idle_stop in idle mode blocks interrupts; comparators stay enabled.
// R2: comparator B event flag sets when its result changes; else reads zero.
// R3: comparator A event flag sets when its result changes; else reads zero.
// R4: each comparator works only while its on bit is one.
// R5: result drives its pad only while the pad-drive bit is one.
// R6: comparator B result is plus-above-minus, complemented when inverted.
// R7: comparator A result is plus-above-minus, complemented when inverted.
// R8: invert bit complements the output; clear passes it unchanged.
// R9: minus select one picks plus pin, zero picks minus pin.
// R10: plus select one picks plus pin, zero picks internal reference.
// R11: reference power bit powers the ladder up or down.
// R12: reference pin-output bit connects reference level to its pin.
// R13: two ranges of 16 levels: span/24 steps, or span/32 plus quarter.
// R14: source select picks external reference pins or analog supply rails.
// R15: level 0..15 sets output: level/24 span, or span/4 plus level/32.
// R16: software waits for reference settling before trusting results.
// R17: event flags stay set until written zero; new events raise interrupts.
// R18: change detection compares synced inverted result with its last sample.
module dcc_top (
	input wire logic MCLK,
	input wire logic RST_N,
	input wire logic IDLE_MODE,
	input wire logic CMP_A_RAW,
	input wire logic CMP_B_RAW,
	output logic CMP_A_ON,
	output logic CMP_B_ON,
	output logic CMP_A_PLUS_SELECT,
	output logic CMP_A_MINUS_SELECT,
	output logic CMP_B_PLUS_SELECT,
	output logic CMP_B_MINUS_SELECT,
	output logic CMP_A_PAD_O,
	output logic CMP_A_PAD_OE,
	output logic CMP_B_PAD_O,
	output logic CMP_B_PAD_OE,
	output logic REF_POWER,
	output logic REF_PIN_OUTPUT,
	output logic REF_RANGE_SELECT,
	output logic REF_SOURCE_SELECT,
	output logic [3:0] REF_LEVEL,
	output logic [6:0] REF_FRACTION,
	output logic IRQ,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	logic [15:0] cmp_cfg;
	logic [15:0] ref_cfg;
	logic [1:0] evt;
	logic [1:0] res;
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] int_status;
	logic [1:0] int_mask;
	logic [6:0] ref_frac;
	logic irq;
	logic bvalid;
	logic [1:0] bresp;
	logic rvalid;
	logic [1:0] rresp;
	logic [31:0] rdata;

	logic wr_take;
	logic rd_take;
	logic wr_cmp;
	logic wr_ref;
	logic wr_mask;
	logic rd_status;
	logic [1:0] on;
	logic [1:0] inv;
	logic [1:0] pad;
	logic [1:0] next_res;
	logic [1:0] chg;
	logic [1:0] clr_evt;
	logic idle_block;
	logic [15:0] cmp_view;
	logic [15:0] wbits;
	logic [3:0] level;

	assign on = {cmp_cfg[dcc_pkg::ON_B_BIT], cmp_cfg[dcc_pkg::ON_A_BIT]};
	assign inv = {cmp_cfg[dcc_pkg::INV_B_BIT], cmp_cfg[dcc_pkg::INV_A_BIT]};
	assign pad = {cmp_cfg[dcc_pkg::PAD_B_BIT], cmp_cfg[dcc_pkg::PAD_A_BIT]};
	assign level = ref_cfg[dcc_pkg::REF_LEVEL_LSB +: dcc_pkg::REF_LEVEL_W];

	// ---------------- bus slave ----------------
	// address and data are taken together; a master offering one first
	// simply waits, which AXI permits since ready may depend on valid
	assign wr_take = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid;
	assign rd_take = S_AXI_ARVALID & ~rvalid;
	assign S_AXI_AWREADY = wr_take;
	assign S_AXI_WREADY = wr_take;
	assign S_AXI_ARREADY = ~rvalid;
	assign wr_cmp = wr_take & (S_AXI_AWADDR == dcc_pkg::ADDR_CMP_CTRL);
	assign wr_ref = wr_take & (S_AXI_AWADDR == dcc_pkg::ADDR_REF_CTRL);
	assign wr_mask = wr_take & (S_AXI_AWADDR == dcc_pkg::ADDR_INT_MASK);
	assign rd_status = rd_take & (S_AXI_ARADDR == dcc_pkg::ADDR_INT_STATUS);
	// byte lanes 0 and 1 cover the 16 implemented bits
	assign wbits = {{8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			bvalid <= 1'b0;
			bresp <= dcc_pkg::RESP_OKAY;
		end else if (wr_take) begin
			bvalid <= 1'b1;
			if (wr_cmp || wr_ref || wr_mask ||
			    S_AXI_AWADDR == dcc_pkg::ADDR_INT_STATUS) begin
				bresp <= dcc_pkg::RESP_OKAY;
			end else begin
				bresp <= dcc_pkg::RESP_SLVERR;
			end
		end else if (S_AXI_BREADY) begin
			bvalid <= 1'b0;
		end
	end

	assign cmp_view = cmp_cfg |
		(16'(evt[1]) << dcc_pkg::EVT_B_BIT) |
		(16'(evt[0]) << dcc_pkg::EVT_A_BIT) |
		(16'(res[1]) << dcc_pkg::RES_B_BIT) |
		(16'(res[0]) << dcc_pkg::RES_A_BIT);

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rvalid <= 1'b0;
			rresp <= dcc_pkg::RESP_OKAY;
			rdata <= 32'h0000_0000;
		end else if (rd_take) begin
			rvalid <= 1'b1;
			rresp <= dcc_pkg::RESP_OKAY;
			case (S_AXI_ARADDR)
				dcc_pkg::ADDR_CMP_CTRL: rdata <= {16'h0000, cmp_view};
				dcc_pkg::ADDR_REF_CTRL: rdata <= {16'h0000, ref_cfg};
				dcc_pkg::ADDR_INT_STATUS: rdata <= {30'h0000_0000, int_status};
				dcc_pkg::ADDR_INT_MASK: rdata <= {30'h0000_0000, int_mask};
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= dcc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (S_AXI_RREADY) begin
			rvalid <= 1'b0;
		end
	end

	assign S_AXI_BVALID = bvalid;
	assign S_AXI_BRESP = bresp;
	assign S_AXI_RVALID = rvalid;
	assign S_AXI_RRESP = rresp;
	assign S_AXI_RDATA = rdata;

	// ---------------- configuration registers ----------------
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			cmp_cfg <= dcc_pkg::CMP_CTRL_RESET;
		end else if (wr_cmp) begin
			cmp_cfg <= (cmp_cfg & ~(wbits & dcc_pkg::CMP_CTRL_WMASK)) |
				(S_AXI_WDATA[15:0] & wbits & dcc_pkg::CMP_CTRL_WMASK);
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ref_cfg <= dcc_pkg::REF_CTRL_RESET;
		end else if (wr_ref) begin
			ref_cfg <= (ref_cfg & ~(wbits & dcc_pkg::REF_CTRL_WMASK)) |
				(S_AXI_WDATA[15:0] & wbits & dcc_pkg::REF_CTRL_WMASK);
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			int_mask <= dcc_pkg::INT_MASK_RESET;
		end else if (wr_mask && S_AXI_WSTRB[0]) begin
			int_mask <= S_AXI_WDATA[1:0];
		end
	end

	// ---------------- comparator results and events ----------------
	// two flops because the analog decision is asynchronous to MCLK
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			sync1 <= 2'h0;
			sync2 <= 2'h0;
		end else begin
			sync1 <= {CMP_B_RAW, CMP_A_RAW};
			sync2 <= sync1;
		end
	end

	// a disabled comparator reads zero and reports no change
	assign next_res = on & (sync2 ^ inv); // R4 R6 R7 R8
	assign chg = on & (next_res ^ res); // R18

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			res <= 2'h0;
		end else begin
			res <= next_res;
		end
	end

	// writing zero clears a flag, writing one leaves it; a change in the
	// same cycle as the clearing write keeps the flag set
	assign clr_evt[1] = wr_cmp & S_AXI_WSTRB[1] &
		~S_AXI_WDATA[dcc_pkg::EVT_B_BIT];
	assign clr_evt[0] = wr_cmp & S_AXI_WSTRB[1] &
		~S_AXI_WDATA[dcc_pkg::EVT_A_BIT];

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			evt <= 2'h0;
		end else begin
			evt[1] <= chg[1] | (evt[1] & ~clr_evt[1]); // R2 R17
			evt[0] <= chg[0] | (evt[0] & ~clr_evt[0]); // R3 R17
		end
	end

	// ---------------- interrupt ----------------
	// comparators keep running while idle; only the request is held back
	assign idle_block = cmp_cfg[dcc_pkg::IDLE_STOP_BIT] & IDLE_MODE; // R1

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			int_status <= dcc_pkg::INT_STATUS_RESET;
		end else begin
			int_status <= (chg & {2{~idle_block}}) | // R1 R17
				(int_status & {2{~rd_status}});
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status & int_mask);
		end
	end

	assign IRQ = irq;

	// ---------------- reference ladder ----------------
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ref_frac <= dcc_pkg::REF_FRAC_RESET;
		end else if (ref_cfg[dcc_pkg::REF_RANGE_BIT]) begin
			ref_frac <= 7'(level * dcc_pkg::REF_FINE_STEP); // R13 R15
		end else begin
			ref_frac <= dcc_pkg::REF_COARSE_BASE +
				7'(level * dcc_pkg::REF_COARSE_STEP); // R13 R15
		end
	end

	assign REF_FRACTION = ref_frac;
	assign REF_POWER = ref_cfg[dcc_pkg::REF_POWER_BIT]; // R11
	assign REF_PIN_OUTPUT = ref_cfg[dcc_pkg::REF_PIN_BIT]; // R12
	assign REF_RANGE_SELECT = ref_cfg[dcc_pkg::REF_RANGE_BIT]; // R13
	assign REF_SOURCE_SELECT = ref_cfg[dcc_pkg::REF_SRC_BIT]; // R14
	assign REF_LEVEL = level; // R15

	// ---------------- analog controls and pads ----------------
	assign CMP_A_ON = on[0]; // R4
	assign CMP_B_ON = on[1]; // R4
	assign CMP_A_PLUS_SELECT = cmp_cfg[dcc_pkg::PLUS_A_BIT]; // R10
	assign CMP_B_PLUS_SELECT = cmp_cfg[dcc_pkg::PLUS_B_BIT]; // R10
	assign CMP_A_MINUS_SELECT = cmp_cfg[dcc_pkg::MINUS_A_BIT]; // R9
	assign CMP_B_MINUS_SELECT = cmp_cfg[dcc_pkg::MINUS_B_BIT]; // R9
	assign CMP_A_PAD_O = res[0];
	assign CMP_B_PAD_O = res[1];
	assign CMP_A_PAD_OE = pad[0]; // R5
	assign CMP_B_PAD_OE = pad[1]; // R5

	// ---------------- checks ----------------
	a_idle_no_irq: assert property (@(posedge MCLK) disable iff (!RST_N) // R1
		idle_block |=> (int_status & ~$past(int_status)) == 2'h0)
		else $error("interrupt status rose while idle stop held");

	a_evt_b_set: assert property (@(posedge MCLK) disable iff (!RST_N) // R2
		chg[1] |=> evt[1] && cmp_view[dcc_pkg::EVT_B_BIT])
		else $error("comparator B change did not set its flag");

	a_evt_a_set: assert property (@(posedge MCLK) disable iff (!RST_N) // R3
		chg[0] |=> evt[0] && cmp_view[dcc_pkg::EVT_A_BIT])
		else $error("comparator A change did not set its flag");

	a_off_reads_zero: assert property (@(posedge MCLK) disable iff (!RST_N) // R4
		!on[0] && !on[1] |=> res == 2'h0 && !evt[0] || $past(evt[0]))
		else $error("disabled comparator produced a result");

	a_pad_gated: assert property (@(posedge MCLK) disable iff (!RST_N) // R5
		!cmp_cfg[dcc_pkg::PAD_B_BIT] |-> !CMP_B_PAD_OE)
		else $error("comparator B pad driven without pad drive");

	a_pad_b_write: assert property (@(posedge MCLK) disable iff (!RST_N) // R5
		wr_cmp && S_AXI_WSTRB[1] |=>
		CMP_B_PAD_OE == $past(S_AXI_WDATA[dcc_pkg::PAD_B_BIT]))
		else $error("comparator B pad enable does not follow its write");

	a_result_b_val: assert property (@(posedge MCLK) disable iff (!RST_N) // R6
		on[1] ##1 on[1] |->
		res[1] == ($past(CMP_B_RAW, 3) ^ $past(inv[1])))
		else $error("comparator B result wrong");

	a_result_a_val: assert property (@(posedge MCLK) disable iff (!RST_N) // R7
		on[0] ##1 on[0] |->
		res[0] == ($past(CMP_A_RAW, 3) ^ $past(inv[0])))
		else $error("comparator A result wrong");

	a_ref_level_map: assert property (@(posedge MCLK) disable iff (!RST_N) // R15
		$stable(ref_cfg) |=> ref_frac == ($past(REF_RANGE_SELECT) ?
		7'($past(level) * 4) : 7'(24 + $past(level) * 3)))
		else $error("reference fraction does not match level");

	a_evt_sticky: assert property (@(posedge MCLK) disable iff (!RST_N) // R17
		evt[0] && !clr_evt[0] |=> evt[0])
		else $error("comparator A flag cleared without a write");

	a_irq_follows: assert property (@(posedge MCLK) disable iff (!RST_N) // R17
		|(int_status & int_mask) |=> IRQ)
		else $error("unmasked status did not raise the interrupt");

	// a masked status bit must stay silent on the interrupt line
	a_irq_masked: assert property (@(posedge MCLK) disable iff (!RST_N) // R17
		(int_status & int_mask) == 2'h0 |=> !IRQ)
		else $error("interrupt raised with every status bit masked");

	a_status_set: assert property (@(posedge MCLK) disable iff (!RST_N) // R17
		chg != 2'h0 && !idle_block |=>
		(int_status & $past(chg)) == $past(chg))
		else $error("comparator change did not set interrupt status");
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// bench for the dual comparator control block over AXI4-Lite.
// assumes the analog model feeds the raw decisions back.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic MCLK = 0, RST_N = 0, IDLE_MODE = 0;
	logic a_raw, b_raw, a_on, b_on, a_ps, a_ms, b_ps, b_ms;
	logic a_o, a_oe, b_o, b_oe, rpw, rpin, rrng, rsrc, irq;
	logic [3:0] rlev;
	logic [6:0] rfrac;
	logic [6:0] a_p = 7'h00, a_m = 7'h00, b_m = 7'h00;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	initial forever #5 MCLK = ~MCLK;
	dcc_top dcc_top_inst (.MCLK(MCLK), .RST_N(RST_N), .IDLE_MODE(IDLE_MODE),
		.CMP_A_RAW(a_raw), .CMP_B_RAW(b_raw), .CMP_A_ON(a_on), .CMP_B_ON(b_on),
		.CMP_A_PLUS_SELECT(a_ps), .CMP_A_MINUS_SELECT(a_ms),
		.CMP_B_PLUS_SELECT(b_ps), .CMP_B_MINUS_SELECT(b_ms),
		.CMP_A_PAD_O(a_o), .CMP_A_PAD_OE(a_oe), .CMP_B_PAD_O(b_o),
		.CMP_B_PAD_OE(b_oe), .REF_POWER(rpw), .REF_PIN_OUTPUT(rpin),
		.REF_RANGE_SELECT(rrng), .REF_SOURCE_SELECT(rsrc), .REF_LEVEL(rlev),
		.REF_FRACTION(rfrac), .IRQ(irq), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
		.S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready));
	dcc_analog_model dcc_analog_model_inst (.on(a_on), .plus_select(a_ps),
		.minus_select(a_ms), .ref_power(rpw), .ref_fraction(rfrac),
		.plus_pin(a_p), .minus_pin(a_m), .raw(a_raw));
	dcc_analog_model dcc_analog_model_b_inst (.on(b_on), .plus_select(b_ps),
		.minus_select(b_ms), .ref_power(rpw), .ref_fraction(rfrac),
		.plus_pin(7'h00), .minus_pin(b_m), .raw(b_raw));
	task automatic print_verdict;
		$display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// bus tasks start one edge late so a ready line is never set twice
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		logic done;
		done = 0;
		@(posedge MCLK);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!done) begin
			@(posedge MCLK);
			if (awvalid && awready)
				awvalid <= 0;
			if (wvalid && wready)
				wvalid <= 0;
			if (bvalid && bready) begin
				done = 1;
				bready <= 0;
				check({30'h0, bresp}, {30'h0, r});
			end
		end
	endtask
	task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] r);
		logic done;
		done = 0;
		@(posedge MCLK);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		while (!done) begin
			@(posedge MCLK);
			if (arvalid && arready)
				arvalid <= 0;
			if (rvalid && rready) begin
				done = 1;
				rready <= 0;
				check(rdata, e);
				check({30'h0, rresp}, {30'h0, r});
			end
		end
	endtask
	task automatic settle;
		repeat (6) @(posedge MCLK);
		#1;
	endtask
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end
	initial begin
		repeat (16) @(posedge MCLK);
		RST_N <= 1;
		for (int i = 0; i < 4; i++)
			axi_rd(8'(i * 4), 32'h0, 2'h0);
		check({25'h0, rfrac}, 32'h18);
		axi_wr(8'h04, 32'hFFFF, 2'h0);
		axi_rd(8'h04, 32'h00FF, 2'h0);
		settle();
		check({rpw, rpin, rrng, rsrc, rlev}, 32'hFF);
		check({25'h0, rfrac}, 32'h3C);
		axi_wr(8'h04, 32'h008F, 2'h0);
		settle();
		check({25'h0, rfrac}, 32'h45);
		check({rpw, rpin, rrng, rsrc}, 32'h8);
		axi_wr(8'h0C, 32'h3, 2'h0);
		a_p <= 7'h46;
		a_m <= 7'h1E;
		axi_wr(8'h00, 32'h0501, 2'h0);
		settle();
		check({a_on, a_oe, a_o, irq}, 32'hF);
		check({a_ps, a_ms, b_ps, b_ms}, 32'h8);
		axi_rd(8'h00, 32'h1541, 2'h0);
		axi_rd(8'h08, 32'h1, 2'h0);
		settle();
		check({31'h0, irq}, 32'h0);
		axi_wr(8'h00, 32'h0501, 2'h0);
		axi_rd(8'h00, 32'h0541, 2'h0);
		axi_wr(8'h00, 32'h0511, 2'h0);
		settle();
		check({31'h0, a_o}, 32'h0);
		axi_rd(8'h00, 32'h1511, 2'h0);
		b_m <= 7'h32;
		axi_wr(8'h00, 32'h0A00, 2'h0);
		settle();
		check({a_on, b_on, b_oe, b_o}, 32'h7);
		axi_rd(8'h00, 32'h2A80, 2'h0);
		axi_rd(8'h08, 32'h3, 2'h0);
		IDLE_MODE <= 1;
		axi_wr(8'h00, 32'h8A00, 2'h0);
		b_m <= 7'h50;
		settle();
		axi_rd(8'h00, 32'hAA00, 2'h0);
		axi_rd(8'h08, 32'h0, 2'h0);
		check({31'h0, irq}, 32'h0);
		IDLE_MODE <= 0;
		axi_wr(8'h00, 32'h0A00, 2'h0);
		b_m <= 7'h28;
		settle();
		axi_rd(8'h08, 32'h2, 2'h0);
		// A minus input moved to the plus pin: equal inputs, no decision
		axi_wr(8'h00, 32'h040B, 2'h0);
		settle();
		check({a_ps, a_ms, b_ps, b_ms}, 32'hD);
		check({31'h0, a_o}, 32'h0);
		axi_rd(8'h00, 32'h040B, 2'h0);
		axi_rd(8'h08, 32'h0, 2'h0);
		// B event with its interrupt masked off
		axi_wr(8'h0C, 32'h1, 2'h0);
		axi_wr(8'h00, 32'h0A00, 2'h0);
		settle();
		check({31'h0, irq}, 32'h0);
		axi_rd(8'h08, 32'h2, 2'h0);
		axi_wr(8'h10, 32'hFFFF, 2'h2);
		axi_rd(8'h10, 32'h0, 2'h2);
		print_verdict();
	end
endmodule
`default_nettype wire
